// ---- dv/iods_chk_asserts.sv ----
/*
 Port checker for the I/O diagnostic supervisor.
 Assumes it is bound to iods_top and that clk_en is held high.
*/
`timescale 1ns/100ps
`include "iods_regs.vh"
module iods_chk (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Watched inputs
  input wire [23:0] input_group0_mode_setting,
  input wire adc_valid,
  input wire [2:0] adc_chan,
  input wire [11:0] adc_data,
  input wire [31:0] input_group1to4_negative,
  input wire [7:0] out_cmd,
  input wire [7:0] out_pwm_mode,
  input wire [7:0] out_diag_en,
  input wire [7:0] out_short_pin,
  // Watched outputs
  input wire [7:0] current_range_sel,
  input wire [7:0] adc_test_req,
  input wire [7:0] input_group0_error_byte,
  input wire [31:0] freq_meas_en,
  input wire [31:0] output_group4_mode_setting,
  input wire [7:0] out_drive_en,
  input wire [7:0] out_logic_state,
  input wire [7:0] output_short_flag,
  input wire [7:0] output_break_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  wire cur0 = input_group0_mode_setting[2:0] == `IODS_IN_CURRENT;
  wire smp0 = adc_valid && adc_chan == 3'h0 && cur0;

  logic_follow_a: assert property (out_logic_state == out_cmd)
    else $error("logic state differs from command");
  overrange_sw_a: assert property (smp0 && adc_data > `IODS_CUR_LIMIT |->
    ##2 !current_range_sel[0] && input_group0_error_byte[0])
    else $error("overrange did not switch range or set error bit");
  range_return_a: assert property (smp0 && adc_data <= `IODS_CUR_LIMIT |->
    ##2 current_range_sel[0]) else $error("range did not return");
  freq_neg_a: assert property ((freq_meas_en & $past(input_group1to4_negative)) == 32'h0000_0000)
    else $error("frequency measurement on negative input");
  pwm_noflag_a: assert property (((output_short_flag | output_break_flag) &
    ~$past(output_short_flag | output_break_flag) & $past(out_pwm_mode)) == 8'h00)
    else $error("flag raised on pwm output");
  short_shutoff_a: assert property ($rose(output_short_flag[0]) |-> !out_drive_en[0])
    else $error("driver left on at short");
  short_latency_a: assert property ($rose(out_short_pin[0]) ##0 (out_short_pin[0] &&
    out_cmd[0] && out_diag_en[0] && !out_pwm_mode[0])[*5] |-> output_short_flag[0])
    else $error("short flag late");
  drive_cause_a: assert property ($fell(out_drive_en[0]) && out_cmd[0] && $past(out_cmd[0])
    |-> output_short_flag[0]) else $error("driver cut without short");
  group4_rst_a: assert property ($fell(reset) |-> output_group4_mode_setting == 32'h0000_0000)
    else $error("group 4 outputs not off after reset");
  test_req_a: assert property (adc_test_req[1] |->
    $past(input_group0_mode_setting[5:3]) == `IODS_IN_SAFETY) else $error("self-test outside mode");

  cover property ($rose(output_short_flag[0]));
  cover property ($rose(adc_test_req[1]));
  cover property ($fell(current_range_sel[0]));
endmodule // iods_chk

bind iods_top iods_chk iods_chk_i (.sys_clk(sys_clk), .reset(reset),
  .input_group0_mode_setting(input_group0_mode_setting), .adc_valid(adc_valid),
  .adc_chan(adc_chan), .adc_data(adc_data), .input_group1to4_negative(input_group1to4_negative),
  .out_cmd(out_cmd), .out_pwm_mode(out_pwm_mode), .out_diag_en(out_diag_en),
  .out_short_pin(out_short_pin), .current_range_sel(current_range_sel),
  .adc_test_req(adc_test_req), .input_group0_error_byte(input_group0_error_byte),
  .freq_meas_en(freq_meas_en), .output_group4_mode_setting(output_group4_mode_setting),
  .out_drive_en(out_drive_en), .out_logic_state(out_logic_state),
  .output_short_flag(output_short_flag), .output_break_flag(output_break_flag));

// ---- dv/iods_field.sv ----
/*
 Field side model: converter scanning eight channels and output stage pins.
 Assumes the bench sets the fault levels it wants to present.
*/
`timescale 1ns/100ps
module iods_field (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Scenario controls
  input wire [11:0] level,
  input wire test_ok,
  input wire [7:0] short_on,
  input wire [7:0] brk_on,
  input wire [7:0] drive_en,
  // Converter
  output reg adc_valid,
  output reg [2:0] adc_chan,
  output wire [11:0] adc_data,
  output wire adc_test_ok,
  // Output stage pins
  output wire [7:0] short_pin,
  output wire [7:0] break_pin
);
  // Data lines are not held once the strobe is gone
  assign adc_data = adc_valid ? level : ~level;
  assign adc_test_ok = adc_valid ? test_ok : ~test_ok;
  assign short_pin = short_on;
  // A break only shows while the driver pushes current
  assign break_pin = brk_on & drive_en;

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      adc_valid <= 1'b0;
      adc_chan <= 3'h0;
    end else begin
      adc_valid <= 1'b1;
      adc_chan <= adc_valid ? adc_chan + 3'h1 : 3'h0;
    end
  end
endmodule // iods_field

// ---- dv/testbench.sv ----
/*
 Self-checking bench for iods_top with the field model.
 Assumes a 250 MHz clock and clk_en tied high.
*/
`timescale 1ns/100ps
`include "iods_regs.vh"
module testbench;
  reg sys_clk = 1'b0;
  reg reset = 1'b1;
  reg [23:0] mode0 = 24'h00_0000;
  reg [11:0] level = 12'h0_100;
  reg test_ok = 1'b1, we = 1'b0, relay = 1'b1;
  reg [2:0] rsel = 3'h0;
  reg [31:0] neg = 32'h0000_0000, den = 32'h0000_0000, fast = 32'h0000_0000;
  reg [31:0] wire_on = 32'h0000_0000, wd = 32'h0000_0000;
  reg [7:0] cmd = 8'h00, pwm = 8'h00, odiag = 8'h00, short_on = 8'h00, brk_on = 8'h00, clr = 8'h00;
  wire valid, ok, dflag, afault, iofault, supply;
  wire [2:0] chan;
  wire [11:0] data, result;
  wire [7:0] rng, req, err0, drv, lgc, sflag, bflag, spin, bpin;
  wire [31:0] freq, g4;
  integer fails = 0, compares = 0, cyc = 0, n;

  iods_field iods_field_i (.sys_clk(sys_clk), .reset(reset), .level(level), .test_ok(test_ok),
    .short_on(short_on), .brk_on(brk_on), .drive_en(drv), .adc_valid(valid), .adc_chan(chan),
    .adc_data(data), .adc_test_ok(ok), .short_pin(spin), .break_pin(bpin));
  iods_top iods_top_i (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1),
    .input_group0_mode_setting(mode0), .input_group0_diag_en(8'h00), .adc_valid(valid),
    .adc_chan(chan), .adc_data(data), .adc_test_ok(ok), .current_range_sel(rng),
    .adc_test_req(req), .result_sel(rsel), .analog_result_vars(result),
    .input_group0_error_byte(err0), .analog_fault_flag(afault), .io_fault_flag(iofault),
    .input_group1to4_negative(neg), .input_group1to4_diag_en(den), .input_group1to4_fast_en(fast),
    .input_wire_fault_pin(wire_on), .freq_meas_en(freq), .input_diag_group_flag(dflag),
    .output_group4_mode_we(we), .output_group4_mode_wdata(wd), .output_group4_mode_setting(g4),
    .out_cmd(cmd), .out_pwm_mode(pwm), .out_diag_en(odiag), .out_short_pin(spin),
    .out_overload_pin(8'h00), .out_break_pin(bpin), .out_flag_clear(clr), .out_drive_en(drv),
    .out_logic_state(lgc), .output_short_flag(sflag), .output_break_flag(bflag),
    .relay_ctrl(relay), .monitored_output_supply_group(supply));

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  task step(input integer k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task check(input [31:0] seen, input [31:0] exp, input string what);
    compares = compares + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("mismatch %0s expected %h seen %h", what, exp, seen);
    end
  endtask

  task end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task t_group4;
    check(g4, 32'h0000_0000, "g4_reset");
    wd = 32'h1111_1111;
    we = 1'b1;
    step(1);
    check(g4, 32'h1111_1111, "g4_write");
    wd = {8{1'b0, `IODS_OUTPUT_DISABLED_CONSTANT}};
    step(1);
    we = 1'b0;
    step(1);
    check(g4, 32'h0000_0000, "g4_nomode");
    $display("test group4 done");
  endtask

  task t_range;
    mode0 = {18'h0_0000, `IODS_IN_DIG_H, `IODS_IN_CURRENT};
    level = `IODS_CUR_LIMIT + 12'h0_001;
    step(20);
    check(rng[1], 1'b0, "range_digital");
    check(rng[0], 1'b0, "range_over");
    check(err0[0], 1'b1, "err_over");
    level = `IODS_CUR_LIMIT;
    step(20);
    check(rng[0], 1'b1, "range_back");
    step(2);
    check(result, `IODS_CUR_LIMIT, "result0");
    check(result > 12'h0_199 && result < 12'h0_E66, 1'b1, "result_window");
    $display("test range done");
  endtask

  task t_selftest;
    mode0 = {18'h0_0000, `IODS_IN_SAFETY, `IODS_IN_CURRENT};
    test_ok = 1'b0;
    n = 0;
    while (req[1] !== 1'b1 && n < 12000) begin
      step(1);
      n = n + 1;
    end
    check(req[1], 1'b1, "test_req");
    step(20);
    check({err0[1], afault, iofault}, 3'h7, "test_fail");
    test_ok = 1'b1;
    mode0 = 24'h00_0000;
    step(20);
    $display("test selftest done");
  endtask

  task t_inputs;
    fast = 32'hFFFF_FFFF;
    neg = 32'h0000_FFFF;
    den = 32'hFFFF_FFFF;
    wire_on = 32'h0000_0001;
    step(6);
    check(freq, 32'hFFFF_0000, "freq_en");
    check(dflag, 1'b0, "diag_neg");
    wire_on = 32'h0001_0000;
    step(6);
    check(dflag, 1'b1, "diag_pos");
    wire_on = 32'h0000_0000;
    $display("test inputs done");
  endtask

  task t_outputs;
    cmd = 8'h07;
    pwm = 8'h02;
    odiag = 8'hFF;
    short_on = 8'h03;
    brk_on = 8'h04;
    step(6);
    check(sflag, 8'h01, "short_flag");
    check(sflag[1] | bflag[1], 1'b0, "pwm_flag");
    check(bflag, 8'h04, "break_flag");
    check(drv & 8'h05, 8'h04, "drive_cut");
    check(lgc, 8'h07, "logic_kept");
    n = 0;
    while (drv[0] !== 1'b1 && n < 80000) begin
      step(1);
      n = n + 1;
    end
    check(drv[0], 1'b1, "retry");
    step(100);
    check(drv[0], 1'b1, "retry_on_time");
    short_on = 8'h00;
    brk_on = 8'h00;
    cmd = 8'h00;
    step(5);
    clr = 8'hFF;
    step(2);
    clr = 8'h00;
    step(3);
    check(sflag | bflag, 8'h00, "flags_clr");
    check(supply, 1'b1, "relay_on");
    relay = 1'b0;
    step(3);
    check(supply, 1'b0, "relay_off");
    $display("test outputs done");
  endtask

  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 99000) begin
      fails = fails + 1;
      end_sim;
    end
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    #1 reset = 1'b0;
    step(1);
    t_group4;
    t_range;
    t_selftest;
    t_inputs;
    t_outputs;
    end_sim;
  end
endmodule // testbench

// ---- verilog/iods_regs.vh ----
/*
 Constants of the I/O diagnostic supervisor: mode codes, field positions,
 reset values and timing counts. Assumes a 250 MHz sys_clk.
*/
`ifndef IODS_REGS_VH
`define IODS_REGS_VH

// Input mode codes (3 bits per channel)
`define IODS_IN_OFF 3'h0
`define IODS_IN_CURRENT 3'h1
`define IODS_IN_VOLT 3'h2
`define IODS_IN_SAFETY 3'h3
`define IODS_IN_DIG_H 3'h4
`define IODS_IN_DIG_NEG 3'h5
// Input mode field bits
`define IODS_IN_DIAG_BIT 3
`define IODS_IN_FAST_BIT 4
// Output mode codes
`define IODS_OUTPUT_DISABLED_CONSTANT 3'h0
`define IODS_OUT_DIG_H 3'h1
`define IODS_OUT_PWM 3'h2
`define IODS_OUT_DIAG_BIT 3
`define IODS_OUT_RESET_MODE 4'h0
// Analogue thresholds on 12-bit results
`define IODS_ADC_W 12
`define IODS_CUR_LIMIT 12'h0_D70
// Timing, clock 4 ns
`define IODS_CLK_NS 4
`define IODS_SHORT_ON_US 50
// 50 us at 4 ns per cycle; overload on-time is eight times longer
`define IODS_SHORT_ON_CYC 20'h0_30D4
`define IODS_OVL_ON_CYC 20'h1_86A0
`define IODS_WAIT_BASE_CYC 20'h0_C350
`define IODS_ADC_TEST_CYC 20'h0_2710

`endif

// ---- verilog/iods_result_mem.v ----
/*
 Eight-word memory holding the published analogue results of input group 0.
 Assumes a single writer; read data is registered.
*/
`timescale 1ns/100ps
module iods_result_mem (
  // Clock and enable
  input wire sys_clk,
  input wire clk_en,
  // Write port
  input wire wr_en,
  input wire [2:0] wr_addr,
  input wire [11:0] wr_data,
  // Read port
  input wire [2:0] rd_addr,
  output reg [11:0] rd_data
);

reg [11:0] mem [0:7];

always @(posedge sys_clk) begin
  if (clk_en) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
end

endmodule // iods_result_mem

// ---- verilog/iods_sync.v ----
/*
 Two-flop synchroniser for a bus of pin levels.
 Assumes the inputs are asynchronous to sys_clk.
*/
`timescale 1ns/100ps
module iods_sync #(
  parameter W = 8
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  input wire clk_en,
  // Data
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);

reg [W-1:0] meta_r;

always @(posedge sys_clk or posedge reset) begin
  if (reset) begin
    meta_r <= {W{1'b0}};
    dout <= {W{1'b0}};
  end else if (clk_en) begin
    meta_r <= din;
    dout <= meta_r;
  end
end

endmodule // iods_sync

// ---- verilog/iods_top.v ----
/*
 I/O diagnostic supervisor: analogue input group 0 modes, overrange
 protection, converter self-test, input diagnostics, group 4 output mode settings and
 output short/overload/break handling with driver shutdown and retry.
 Assumes a converter presents one channel per cycle with a valid strobe,
 and per-output pin status levels from the output stages.
*/
// Function
// - Current input above limit switches to voltage range, sets error bit.
// - Below limit again, input returns to current range automatically.
// - Safety input mode enables periodic converter self-test for that channel.
// - Self-test failure sets channel error bit, analogue and I/O fault flags.
// - Group 0 analogue results are always published per channel.
// - Diagnosis-enabled inputs of groups 1 to 4 report break or short on one group flag; group 0 enables are ignored.
// - Negative-signal inputs give no diagnostic reporting.
// - Frequency measurement offered only on positive-signal inputs.
// - After reset all eight group 4 outputs are in switched-off mode.
// - PWM outputs: no diagnosis, no error flags, no overload protection.
// - Protective shutoff leaves the commanded output logic unchanged.
// - Outside safety mode, short/overload sets short flag, break sets break flag.
// - Only short or overload disables the driver; commanded logic stays.
// - Driver retried after waiting time that grows with overload.
// - Retry on-time is short into a short, longer under overload.
// - Flag cleared by software, then relay re-enables the supply group.
`timescale 1ns/100ps
`include "iods_regs.vh"
module iods_top (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  input wire clk_en,
  // Input group 0 modes and converter
  input wire [23:0] input_group0_mode_setting,
  input wire [7:0] input_group0_diag_en,
  input wire adc_valid,
  input wire [2:0] adc_chan,
  input wire [11:0] adc_data,
  input wire adc_test_ok,
  output reg [7:0] current_range_sel,
  output reg [7:0] adc_test_req,
  // Input group 0 results
  input wire [2:0] result_sel,
  output wire [11:0] analog_result_vars,
  output reg [7:0] input_group0_error_byte,
  output reg analog_fault_flag,
  output reg io_fault_flag,
  // Input groups 1 to 4
  input wire [31:0] input_group1to4_negative,
  input wire [31:0] input_group1to4_diag_en,
  input wire [31:0] input_group1to4_fast_en,
  input wire [31:0] input_wire_fault_pin,
  output reg [31:0] freq_meas_en,
  output reg input_diag_group_flag,
  // Output group 4 modes
  input wire output_group4_mode_we,
  input wire [31:0] output_group4_mode_wdata,
  output reg [31:0] output_group4_mode_setting,
  // Output channels
  input wire [7:0] out_cmd,
  input wire [7:0] out_pwm_mode,
  input wire [7:0] out_diag_en,
  input wire [7:0] out_short_pin,
  input wire [7:0] out_overload_pin,
  input wire [7:0] out_break_pin,
  input wire [7:0] out_flag_clear,
  output reg [7:0] out_drive_en,
  output wire [7:0] out_logic_state,
  output reg [7:0] output_short_flag,
  output reg [7:0] output_break_flag,
  // Supply relay
  input wire relay_ctrl,
  output reg monitored_output_supply_group
);

////////////////////////////////////////////////////////////////////////////
// Helpers

function [2:0] mode_of;
  input [23:0] modes;
  input [2:0] ch;
  begin
    mode_of = modes[ch*3 +: 3];
  end
endfunction

function [19:0] wait_cycles;
  input ovl;
  input [3:0] level;
  begin
    wait_cycles = ovl ? (`IODS_WAIT_BASE_CYC + {level, 14'h0_000}) : `IODS_WAIT_BASE_CYC;
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

wire [31:0] wire_fault_s;
wire [7:0] short_s;
wire [7:0] ovl_s;
wire [7:0] brk_s;

iods_sync #(.W(32)) u_sync_in (
  .sys_clk(sys_clk),
  .reset(reset),
  .clk_en(clk_en),
  .din(input_wire_fault_pin),
  .dout(wire_fault_s)
);

iods_sync #(.W(24)) u_sync_out (
  .sys_clk(sys_clk),
  .reset(reset),
  .clk_en(clk_en),
  .din({out_short_pin, out_overload_pin, out_break_pin}),
  .dout({short_s, ovl_s, brk_s})
);

////////////////////////////////////////////////////////////////////////////
// Input group 0: overrange, results, self-test

wire [2:0] cur_mode = mode_of(input_group0_mode_setting, adc_chan);
wire over_limit = adc_data > `IODS_CUR_LIMIT;

iods_result_mem u_mem (
  .sys_clk(sys_clk),
  .clk_en(clk_en),
  .wr_en(adc_valid),
  .wr_addr(adc_chan),
  .wr_data(adc_data),
  .rd_addr(result_sel),
  .rd_data(analog_result_vars)
);

reg [19:0] test_cnt_r;
reg [7:0] overrange_r;
reg [7:0] test_fail_r;
integer i;

always @(posedge sys_clk or posedge reset) begin
  if (reset) begin
    test_cnt_r <= 20'h0_0000;
    adc_test_req <= 8'h00;
    overrange_r <= 8'h00;
    test_fail_r <= 8'h00;
    current_range_sel <= 8'h00;
    input_group0_error_byte <= 8'h00;
    analog_fault_flag <= 1'b0;
    io_fault_flag <= 1'b0;
  end else if (clk_en) begin
    if (test_cnt_r == `IODS_ADC_TEST_CYC) begin
      test_cnt_r <= 20'h0_0000;
    end else begin
      test_cnt_r <= test_cnt_r + 20'h0_0001;
    end
    for (i = 0; i < 8; i = i + 1) begin
      adc_test_req[i] <= (test_cnt_r == `IODS_ADC_TEST_CYC) &&
        (mode_of(input_group0_mode_setting, i[2:0]) == `IODS_IN_SAFETY);
      current_range_sel[i] <= (mode_of(input_group0_mode_setting, i[2:0]) ==
        `IODS_IN_CURRENT) && !overrange_r[i];
      if (mode_of(input_group0_mode_setting, i[2:0]) != `IODS_IN_CURRENT) begin
        overrange_r[i] <= 1'b0;
      end
      if (mode_of(input_group0_mode_setting, i[2:0]) != `IODS_IN_SAFETY) begin
        test_fail_r[i] <= 1'b0;
      end
    end
    if (adc_valid && cur_mode == `IODS_IN_CURRENT) begin
      overrange_r[adc_chan] <= over_limit;
    end
    if (adc_valid && cur_mode == `IODS_IN_SAFETY && !adc_test_ok) begin
      test_fail_r[adc_chan] <= 1'b1;
    end
    input_group0_error_byte <= overrange_r | test_fail_r;
    analog_fault_flag <= |test_fail_r;
    io_fault_flag <= (|test_fail_r) | (|output_short_flag) | (|output_break_flag);
  end
end

////////////////////////////////////////////////////////////////////////////
// Input groups 1 to 4 diagnostics

always @(posedge sys_clk or posedge reset) begin
  if (reset) begin
    input_diag_group_flag <= 1'b0;
    freq_meas_en <= 32'h0000_0000;
  end else if (clk_en) begin
    freq_meas_en <= input_group1to4_fast_en & ~input_group1to4_negative;
    input_diag_group_flag <=
      (|(wire_fault_s & input_group1to4_diag_en & ~input_group1to4_negative)) |
      (|input_group0_diag_en & 1'b0);
  end
end

////////////////////////////////////////////////////////////////////////////
// Output group 4 mode settings

always @(posedge sys_clk or posedge reset) begin
  if (reset) begin
    output_group4_mode_setting <= {8{`IODS_OUT_RESET_MODE}};
  end else if (clk_en && output_group4_mode_we) begin
    output_group4_mode_setting <= output_group4_mode_wdata;
  end
end

////////////////////////////////////////////////////////////////////////////
// Output protection: shutoff, waiting time, retry

localparam ST_ON = 3'b001;
localparam ST_OFF = 3'b010;
localparam ST_RETRY = 3'b100;

reg [2:0] st_r [0:7];
reg [19:0] tmr_r [0:7];
reg [3:0] ovl_lvl_r [0:7];
reg [7:0] ovl_cause_r;

assign out_logic_state = out_cmd;

wire [7:0] mon = out_cmd & ~out_pwm_mode & out_diag_en;
wire [7:0] hit = mon & (short_s | ovl_s);

always @(posedge sys_clk or posedge reset) begin
  if (reset) begin
    for (i = 0; i < 8; i = i + 1) begin
      st_r[i] <= ST_ON;
      tmr_r[i] <= 20'h0_0000;
      ovl_lvl_r[i] <= 4'h0;
    end
    ovl_cause_r <= 8'h00;
    out_drive_en <= 8'h00;
    output_short_flag <= 8'h00;
    output_break_flag <= 8'h00;
    monitored_output_supply_group <= 1'b0;
  end else if (clk_en) begin
    for (i = 0; i < 8; i = i + 1) begin
      // Set wins over clear
      output_short_flag[i] <= hit[i] | (output_short_flag[i] & ~out_flag_clear[i]);
      output_break_flag[i] <= (mon[i] & brk_s[i]) |
        (output_break_flag[i] & ~out_flag_clear[i]);
      case (st_r[i])
        ST_ON: begin
          out_drive_en[i] <= out_cmd[i];
          if (hit[i]) begin
            st_r[i] <= ST_OFF;
            out_drive_en[i] <= 1'b0;
            ovl_cause_r[i] <= ~short_s[i];
            tmr_r[i] <= wait_cycles(~short_s[i], ovl_lvl_r[i]);
            if (ovl_lvl_r[i] != 4'hF) begin
              ovl_lvl_r[i] <= ovl_lvl_r[i] + 4'h1;
            end
          end else if (!out_cmd[i]) begin
            ovl_lvl_r[i] <= 4'h0;
          end
        end
        ST_OFF: begin
          out_drive_en[i] <= 1'b0;
          if (!out_cmd[i]) begin
            st_r[i] <= ST_ON;
          end else if (tmr_r[i] == 20'h0_0000) begin
            st_r[i] <= ST_RETRY;
            out_drive_en[i] <= 1'b1;
            tmr_r[i] <= ovl_cause_r[i] ? `IODS_OVL_ON_CYC : `IODS_SHORT_ON_CYC;
          end else begin
            tmr_r[i] <= tmr_r[i] - 20'h0_0001;
          end
        end
        ST_RETRY: begin
          if (!out_cmd[i]) begin
            st_r[i] <= ST_ON;
            out_drive_en[i] <= 1'b0;
          end else if (tmr_r[i] == 20'h0_0000) begin
            if (hit[i]) begin
              st_r[i] <= ST_OFF;
              out_drive_en[i] <= 1'b0;
              ovl_cause_r[i] <= ~short_s[i];
              tmr_r[i] <= wait_cycles(~short_s[i], ovl_lvl_r[i]);
              if (ovl_lvl_r[i] != 4'hF) begin
                ovl_lvl_r[i] <= ovl_lvl_r[i] + 4'h1;
              end
            end else begin
              st_r[i] <= ST_ON;
            end
          end else begin
            tmr_r[i] <= tmr_r[i] - 20'h0_0001;
          end
        end
        default: begin
          st_r[i] <= ST_ON;
          out_drive_en[i] <= 1'b0;
        end
      endcase
    end
    // Relay follows control, held off while any flag stands
    monitored_output_supply_group <= relay_ctrl &
      ~(|output_short_flag) & ~(|output_break_flag);
  end
end

endmodule // iods_top
